// *** shared/ctsw_consts.vh ***
// constants for the commutation threshold and switch configuration block
`ifndef CTSW_CONSTS_VH
`define CTSW_CONSTS_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CTSW_IDX_THRESHOLD 6'h33
`define CTSW_IDX_SWITCH_CFG 6'h34
`define CTSW_IDX_STATUS 6'h35
`define CTSW_IDX_CAPTURED 6'h36
`define CTSW_IDX_CAPTURED_ENC 6'h37

// ----------------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------------
`define CTSW_THRESHOLD_RESET 32'h0000_0000
`define CTSW_THRESHOLD_MASK 32'h007F_FF00
`define CTSW_SWITCH_CFG_RESET 32'h0000_0000
`define CTSW_SWITCH_CFG_MASK 32'h0000_7FFF
`define CTSW_THR_LSB 8
`define CTSW_THR_MSB 22

// ----------------------------------------------------------------------
// switch configuration field positions
// ----------------------------------------------------------------------
`define CTSW_SW_STOP_L_EN 0
`define CTSW_SW_STOP_R_EN 1
`define CTSW_SW_POL_L 2
`define CTSW_SW_POL_R 3
`define CTSW_SW_EXCHANGE 4
`define CTSW_SW_LATCH_L_ACT 5
`define CTSW_SW_LATCH_L_INACT 6
`define CTSW_SW_LATCH_R_ACT 7
`define CTSW_SW_LATCH_R_INACT 8
`define CTSW_SW_LATCH_ENC 9
`define CTSW_SW_STALL_HALT 10
`define CTSW_SW_SOFT_STOP 11
`define CTSW_SW_VSTOP_L_EN 12
`define CTSW_SW_VSTOP_R_EN 13
`define CTSW_SW_VSTOP_ENC 14

// ----------------------------------------------------------------------
// status register bits
// ----------------------------------------------------------------------
`define CTSW_ST_AUTO_COMM 0
`define CTSW_ST_STOP 1
`define CTSW_ST_LEFT_ACT 2
`define CTSW_ST_RIGHT_ACT 3
`define CTSW_ST_VSTOP_L 4
`define CTSW_ST_VSTOP_R 5
`define CTSW_ST_LATCH_L 6
`define CTSW_ST_LATCH_R 7

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define CTSW_RESP_OKAY 2'h0
`define CTSW_RESP_SLVERR 2'h2

`endif

// *** core/ctsw_pin_sync.v ***
// three-stage pin synchroniser with agreement qualification
`timescale 1ns/1ps
`default_nettype none

module ctsw_pin_sync
(
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // pin and stable level
   input wire pin,
   output reg level_q
);

   reg meta_q;
   reg s2_q;
   reg s3_q;

   // level changes only once stages two and three agree
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end
      else
      begin
         meta_q <= pin;
         s2_q <= meta_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
         begin
            level_q <= s3_q;
         end
      end
   end

endmodule

`default_nettype wire

// *** core/ctsw_top.v ***
// commutation threshold and reference switch configuration block
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ctsw_consts.vh"

module ctsw_top
#(
   parameter ADDR_W = 8
)
(
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // motion state from the ramp and commutation logic
   input wire [31:0] actual_velocity,
   input wire [31:0] actual_position,
   input wire [31:0] encoder_position,
   input wire [31:0] commutation_position,
   input wire heavy_load,
   input wire stall_detected,
   input wire [31:0] virtual_limit_left,
   input wire [31:0] virtual_limit_right,
   // reference switch pins
   input wire left_reference_input,
   input wire right_reference_input,
   // commutation outputs
   output reg auto_commutation_q,
   output reg high_velocity_threshold_q,
   output reg actual_position_load_q,
   output reg [31:0] actual_position_wdata_q,
   output reg step_floor_active_q,
   output reg [31:0] step_velocity_floor_q,
   // stop outputs
   output reg stop_request_q,
   output reg soft_stop_q,
   output reg hard_stop_q,
   output reg zero_wait_request_q,
   // captured positions
   output reg [31:0] captured_position_q,
   output reg [31:0] captured_encoder_q
);

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   function [31:0] ctsw_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] strb;
      input [31:0] mask;
      integer i;
      reg [31:0] r;
      begin
         r = old_v;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (strb[i])
            begin
               r[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
         ctsw_merge = r & mask;
      end
   endfunction

   function [5:0] ctsw_index;
      input [ADDR_W-1:0] addr;
      begin
         ctsw_index = addr[7:2];
      end
   endfunction

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   reg [31:0] threshold_q;
   reg [31:0] switch_cfg_q;
   reg latch_l_flag_q;
   reg latch_r_flag_q;
   reg aw_held_q;
   reg w_held_q;
   reg [ADDR_W-1:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg left_prev_q;
   reg right_prev_q;

   wire left_level;
   wire right_level;
   wire do_write;
   wire [5:0] wr_idx;
   wire [5:0] rd_idx;
   wire clr_l;
   wire clr_r;

   assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
   assign wr_idx = ctsw_index(awaddr_q);
   assign rd_idx = ctsw_index(s_axi_araddr);
   // flags clear by writing ones into the low byte of the status word
   assign clr_l = do_write & (wr_idx == `CTSW_IDX_STATUS) &
                  wstrb_q[0] & wdata_q[`CTSW_ST_LATCH_L];
   assign clr_r = do_write & (wr_idx == `CTSW_IDX_STATUS) &
                  wstrb_q[0] & wdata_q[`CTSW_ST_LATCH_R];

   // -------------------------------------------------------------------
   // reference pin synchronisers
   // -------------------------------------------------------------------
   ctsw_pin_sync u_sync_left
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(left_reference_input),
      .level_q(left_level)
   );

   ctsw_pin_sync u_sync_right
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(right_reference_input),
      .level_q(right_level)
   );

   // -------------------------------------------------------------------
   // threshold comparison
   // -------------------------------------------------------------------
   wire [14:0] thr;
   wire [31:0] vel_mag;
   wire thr_reached;
   wire comm_on;

   assign thr = threshold_q[`CTSW_THR_MSB:`CTSW_THR_LSB];
   assign vel_mag = actual_velocity[31] ? (~actual_velocity + 32'h1)
                                        : actual_velocity;
   // low eight bits of the magnitude take no part
   assign thr_reached = (vel_mag[31:23] != 9'h000) |
                        (vel_mag[22:8] >= thr);
   assign comm_on = (thr != 15'h0000) & thr_reached;

   // -------------------------------------------------------------------
   // switch decode
   // -------------------------------------------------------------------
   wire exch;
   wire left_raw;
   wire right_raw;
   wire left_act;
   wire right_act;
   wire signed [31:0] vs_pos;
   wire vstop_l;
   wire vstop_r;
   wire moving_neg;
   wire moving_pos;
   wire stop_cond;
   wire right_rise;
   wire right_fall;
   wire left_rise;
   wire left_fall;
   wire latch_r_evt;
   wire latch_l_evt;

   assign exch = switch_cfg_q[`CTSW_SW_EXCHANGE];
   assign left_raw = exch ? right_level : left_level;
   assign right_raw = exch ? left_level : right_level;
   // polarity bit set means the switch is active low
   assign left_act = left_raw ^ switch_cfg_q[`CTSW_SW_POL_L];
   assign right_act = right_raw ^ switch_cfg_q[`CTSW_SW_POL_R];
   assign vs_pos = switch_cfg_q[`CTSW_SW_VSTOP_ENC] ? encoder_position
                                                    : actual_position;
   assign vstop_l = vs_pos <= $signed(virtual_limit_left);
   assign vstop_r = vs_pos >= $signed(virtual_limit_right);
   assign moving_neg = actual_velocity[31];
   assign moving_pos = ~actual_velocity[31] & (actual_velocity != 32'h0);
   assign stop_cond =
      (moving_neg & ((switch_cfg_q[`CTSW_SW_STOP_L_EN] & left_act) |
                     (switch_cfg_q[`CTSW_SW_VSTOP_L_EN] & vstop_l))) |
      (moving_pos & ((switch_cfg_q[`CTSW_SW_STOP_R_EN] & right_act) |
                     (switch_cfg_q[`CTSW_SW_VSTOP_R_EN] & vstop_r))) |
      (switch_cfg_q[`CTSW_SW_STALL_HALT] & stall_detected);

   assign right_rise = right_act & ~right_prev_q;
   assign right_fall = ~right_act & right_prev_q;
   assign left_rise = left_act & ~left_prev_q;
   assign left_fall = ~left_act & left_prev_q;
   assign latch_r_evt = (switch_cfg_q[`CTSW_SW_LATCH_R_ACT] & right_rise) |
                        (switch_cfg_q[`CTSW_SW_LATCH_R_INACT] & right_fall);
   assign latch_l_evt = (switch_cfg_q[`CTSW_SW_LATCH_L_ACT] & left_rise) |
                        (switch_cfg_q[`CTSW_SW_LATCH_L_INACT] & left_fall);

   // -------------------------------------------------------------------
   // motion outputs
   // -------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         auto_commutation_q <= 1'b0;
         high_velocity_threshold_q <= 1'b0;
         actual_position_load_q <= 1'b0;
         actual_position_wdata_q <= 32'h0000_0000;
         step_floor_active_q <= 1'b0;
         step_velocity_floor_q <= 32'h0000_0000;
         stop_request_q <= 1'b0;
         soft_stop_q <= 1'b0;
         hard_stop_q <= 1'b0;
         zero_wait_request_q <= 1'b0;
         captured_position_q <= 32'h0000_0000;
         captured_encoder_q <= 32'h0000_0000;
         left_prev_q <= 1'b0;
         right_prev_q <= 1'b0;
         latch_l_flag_q <= 1'b0;
         latch_r_flag_q <= 1'b0;
      end
      else
      begin
         auto_commutation_q <= comm_on;
         high_velocity_threshold_q <= comm_on;
         actual_position_load_q <= comm_on;
         actual_position_wdata_q <= comm_on ? commutation_position
                                            : 32'h0000_0000;
         step_floor_active_q <= comm_on & heavy_load;
         step_velocity_floor_q <= (comm_on & heavy_load) ?
                                  {9'h000, thr, 8'h00} : 32'h0000_0000;
         stop_request_q <= stop_cond;
         soft_stop_q <= stop_cond & switch_cfg_q[`CTSW_SW_SOFT_STOP];
         hard_stop_q <= stop_cond & ~switch_cfg_q[`CTSW_SW_SOFT_STOP];
         zero_wait_request_q <= stop_cond;
         left_prev_q <= left_act;
         right_prev_q <= right_act;
         if (latch_r_evt | latch_l_evt)
         begin
            captured_position_q <= actual_position;
            if (switch_cfg_q[`CTSW_SW_LATCH_ENC])
            begin
               captured_encoder_q <= encoder_position;
            end
         end
         // a new event wins over a clear in the same cycle
         latch_l_flag_q <= latch_l_evt | (latch_l_flag_q & ~clr_l);
         latch_r_flag_q <= latch_r_evt | (latch_r_flag_q & ~clr_r);
      end
   end

   // -------------------------------------------------------------------
   // axi4-lite write channel
   // -------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CTSW_RESP_OKAY;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= {ADDR_W{1'b0}};
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         threshold_q <= `CTSW_THRESHOLD_RESET;
         switch_cfg_q <= `CTSW_SWITCH_CFG_RESET;
      end
      else
      begin
         if (!aw_held_q & !s_axi_bvalid & !s_axi_awready)
         begin
            s_axi_awready <= 1'b1;
         end
         if (!w_held_q & !s_axi_bvalid & !s_axi_wready)
         begin
            s_axi_wready <= 1'b1;
         end
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `CTSW_RESP_OKAY;
            case (wr_idx)
               `CTSW_IDX_THRESHOLD:
                  threshold_q <= ctsw_merge(threshold_q, wdata_q, wstrb_q,
                                            `CTSW_THRESHOLD_MASK);
               `CTSW_IDX_SWITCH_CFG:
                  switch_cfg_q <= ctsw_merge(switch_cfg_q, wdata_q, wstrb_q,
                                             `CTSW_SWITCH_CFG_MASK);
               `CTSW_IDX_STATUS:
                  s_axi_bresp <= `CTSW_RESP_OKAY;
               `CTSW_IDX_CAPTURED:
                  s_axi_bresp <= `CTSW_RESP_OKAY;
               `CTSW_IDX_CAPTURED_ENC:
                  s_axi_bresp <= `CTSW_RESP_OKAY;
               default:
                  s_axi_bresp <= `CTSW_RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // axi4-lite read channel
   // -------------------------------------------------------------------
   reg [31:0] rd_val;
   reg rd_hit;

   always @*
   begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (rd_idx)
         `CTSW_IDX_THRESHOLD:
            rd_val = threshold_q & `CTSW_THRESHOLD_MASK;
         `CTSW_IDX_SWITCH_CFG:
            rd_val = switch_cfg_q;
         `CTSW_IDX_STATUS:
         begin
            rd_val[`CTSW_ST_AUTO_COMM] = auto_commutation_q;
            rd_val[`CTSW_ST_STOP] = stop_request_q;
            rd_val[`CTSW_ST_LEFT_ACT] = left_act;
            rd_val[`CTSW_ST_RIGHT_ACT] = right_act;
            rd_val[`CTSW_ST_VSTOP_L] = vstop_l;
            rd_val[`CTSW_ST_VSTOP_R] = vstop_r;
            rd_val[`CTSW_ST_LATCH_L] = latch_l_flag_q;
            rd_val[`CTSW_ST_LATCH_R] = latch_r_flag_q;
         end
         `CTSW_IDX_CAPTURED:
            rd_val = captured_position_q;
         `CTSW_IDX_CAPTURED_ENC:
            rd_val = captured_encoder_q;
         default:
            rd_hit = 1'b0;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CTSW_RESP_OKAY;
      end
      else
      begin
         if (!s_axi_rvalid & !s_axi_arready)
         begin
            s_axi_arready <= 1'b1;
         end
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? `CTSW_RESP_OKAY : `CTSW_RESP_SLVERR;
         end
         if (s_axi_rvalid & s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// *** dv/ctsw_monitor.sv ***
// assertion checker for the commutation threshold and switch block
`timescale 1ns/1ps
`default_nettype none
module ctsw_monitor
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus responses
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // motion inputs
   input wire logic [31:0] actual_velocity,
   input wire logic [31:0] actual_position,
   input wire logic [31:0] commutation_position,
   input wire logic heavy_load,
   // block outputs
   input wire logic auto_commutation_q,
   input wire logic high_velocity_threshold_q,
   input wire logic actual_position_load_q,
   input wire logic [31:0] actual_position_wdata_q,
   input wire logic step_floor_active_q,
   input wire logic [31:0] step_velocity_floor_q,
   input wire logic stop_request_q,
   input wire logic soft_stop_q,
   input wire logic hard_stop_q,
   input wire logic zero_wait_request_q,
   input wire logic [31:0] captured_position_q
);
   logic [31:0] mag;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // velocity magnitude
   assign mag = actual_velocity[31] ? -actual_velocity : actual_velocity;
   property p_bresp_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bresp_hold: assert property (p_bresp_hold) else $error("bresp dropped");
   property p_rdata_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("rdata dropped");
   property p_auto_speed;
      auto_commutation_q |-> $past(mag) >= 32'h0000_0100;
   endproperty
   a_auto_speed: assert property (p_auto_speed)
      else $error("auto commutation below minimum speed");
   property p_hvt;
      high_velocity_threshold_q == auto_commutation_q;
   endproperty
   a_hvt: assert property (p_hvt) else $error("high velocity flag");
   property p_load;
      actual_position_load_q == auto_commutation_q;
   endproperty
   a_load: assert property (p_load) else $error("position load");
   property p_wdata;
      actual_position_load_q |->
         actual_position_wdata_q == $past(commutation_position);
   endproperty
   a_wdata: assert property (p_wdata) else $error("position data");
   property p_floor;
      step_floor_active_q |-> auto_commutation_q && $past(heavy_load);
   endproperty
   a_floor: assert property (p_floor) else $error("floor active");
   property p_floor_val;
      (step_velocity_floor_q & ~32'h007F_FF00) == 32'h0000_0000 &&
         (step_velocity_floor_q != 32'h0000_0000) == step_floor_active_q;
   endproperty
   a_floor_val: assert property (p_floor_val)
      else $error("floor value");
   property p_stop_kind;
      stop_request_q == (soft_stop_q ^ hard_stop_q);
   endproperty
   a_stop_kind: assert property (p_stop_kind) else $error("stop kind");
   property p_zero_wait;
      stop_request_q |-> zero_wait_request_q;
   endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("zero wait");
   property p_latch;
      $changed(captured_position_q) |->
         captured_position_q == $past(actual_position);
   endproperty
   a_latch: assert property (p_latch) else $error("latched value");
endmodule
bind ctsw_top ctsw_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .actual_velocity(actual_velocity), .actual_position(actual_position),
   .commutation_position(commutation_position), .heavy_load(heavy_load),
   .auto_commutation_q(auto_commutation_q),
   .high_velocity_threshold_q(high_velocity_threshold_q),
   .actual_position_load_q(actual_position_load_q),
   .actual_position_wdata_q(actual_position_wdata_q),
   .step_floor_active_q(step_floor_active_q),
   .step_velocity_floor_q(step_velocity_floor_q),
   .stop_request_q(stop_request_q), .soft_stop_q(soft_stop_q),
   .hard_stop_q(hard_stop_q), .zero_wait_request_q(zero_wait_request_q),
   .captured_position_q(captured_position_q));
`default_nettype wire

// *** dv/tb_commutation_threshold_switch_config.sv ***
// self-checking bench for the commutation threshold and switch block
`timescale 1ns/1ps
`default_nettype none
`include "ctsw_consts.vh"
module tb_commutation_threshold_switch_config;
   localparam logic [7:0] TH = {`CTSW_IDX_THRESHOLD, 2'b00};
   localparam logic [7:0] SW = {`CTSW_IDX_SWITCH_CFG, 2'b00};
   localparam logic [31:0] TM = `CTSW_THRESHOLD_MASK;
   localparam logic [31:0] SM = `CTSW_SWITCH_CFG_MASK;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] vel = 0, pos = 0, enc = 0, cpos = 0, lim_r = 0;
   logic heavy = 0, stall = 0, ref_r = 0;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata, pos_wd, floor_v, cap_p, cap_e;
   wire auto_q, hvt_q, load_q, floor_q, stop_q, soft_q, hard_q, zw_q;
   int n_errors = 0, n_tests = 0;
   logic [1:0] rsp;
   logic [31:0] rd, thr, cfg, d;
   logic [3:0] s;
   logic a;
   always #20 aclk = ~aclk;
   ctsw_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .actual_velocity(vel), .actual_position(pos), .encoder_position(enc),
      .commutation_position(cpos), .heavy_load(heavy),
      .stall_detected(stall), .virtual_limit_left(32'h0),
      .virtual_limit_right(lim_r), .left_reference_input(1'b0),
      .right_reference_input(ref_r), .auto_commutation_q(auto_q),
      .high_velocity_threshold_q(hvt_q), .actual_position_load_q(load_q),
      .actual_position_wdata_q(pos_wd), .step_floor_active_q(floor_q),
      .step_velocity_floor_q(floor_v), .stop_request_q(stop_q),
      .soft_stop_q(soft_q), .hard_stop_q(hard_q),
      .zero_wait_request_q(zw_q), .captured_position_q(cap_p),
      .captured_encoder_q(cap_e));
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt,
                     input logic [3:0] st);
      awaddr <= ad;
      wdata <= dt;
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b1;
      @(posedge aclk);
      rsp = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rdr(input logic [7:0] ad);
      araddr <= ad;
      arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b1;
      @(posedge aclk);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   function automatic logic [31:0] mrg(input logic [31:0] o, n, m,
                                       input logic [3:0] st);
      for (int i = 0; i < 4; i++)
         if (st[i]) o[8*i+:8] = n[8*i+:8];
      return o & m;
   endfunction
   function automatic logic expa(input logic [31:0] t, v);
      logic [31:0] m;
      m = v[31] ? -v : v;
      return t[22:8] != 15'h0 && m[31:8] >= {9'h0, t[22:8]};
   endfunction
   task automatic give_verdict();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      give_verdict();
   end
   initial
   begin
      void'($urandom(78719));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rdr(TH);
      chk("threshold reset", 32'h0, rd);
      rdr(SW);
      chk("switch cfg reset", 32'h0, rd);
      thr = 32'h0;
      cfg = 32'h0;
      for (int i = 0; i < 10; i++)
      begin
         d = $urandom;
         s = (i < 5) ? 4'hF : 4'($urandom);
         wr(TH, d, s);
         thr = mrg(thr, d, TM, s);
         rdr(TH);
         chk("threshold", thr, rd);
         d = $urandom;
         wr(SW, d, s);
         cfg = mrg(cfg, d, SM, s);
         rdr(SW);
         chk("switch cfg", cfg, rd);
      end
      wr(8'hFC, 32'hFFFFFFFF, 4'hF);
      chk("unmapped bresp", 32'h2, {30'h0, rsp});
      rdr(8'hFC);
      chk("unmapped rresp", 32'h2, {30'h0, rsp});
      chk("unmapped rdata", 32'h0, rd);
      wr(SW, 32'h0400, 4'hF);
      for (int i = 0; i < 16; i++)
      begin
         thr = (i == 0) ? 32'h0 : ($urandom & TM);
         case ($urandom % 4)
            0: d = thr;
            1: d = thr - 32'h1;
            2: d = $urandom % (thr * 2 + 32'h2);
            default: d = -thr;
         endcase
         if (i == 0) d = 32'h7FFFFFFF;
         wr(TH, thr, 4'hF);
         vel <= d;
         heavy <= 1'($urandom);
         cpos <= $urandom;
         repeat (3) @(posedge aclk);
         a = expa(thr, vel);
         chk("auto", {31'h0, a}, {31'h0, auto_q});
         chk("high velocity", {31'h0, a}, {31'h0, hvt_q});
         chk("pos load", {31'h0, a}, {31'h0, load_q});
         chk("pos data", a ? cpos : 32'h0, pos_wd);
         chk("floor on", {31'h0, a & heavy}, {31'h0, floor_q});
         chk("floor", (a & heavy) ? thr : 32'h0, floor_v);
      end
      vel <= 32'h0;
      stall <= 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         wr(SW, k ? 32'h0400 : 32'h0C00, 4'hF);
         repeat (3) @(posedge aclk);
         chk("stop", 32'h1, {31'h0, stop_q});
         chk("soft", {31'h0, k == 0}, {31'h0, soft_q});
         chk("hard", {31'h0, k == 1}, {31'h0, hard_q});
         chk("zero wait", 32'h1, {31'h0, zw_q});
      end
      stall <= 1'b0;
      vel <= 32'd100;
      lim_r <= 32'd1000;
      for (int k = 0; k < 2; k++)
      begin
         pos <= k ? 32'd0 : 32'd2000;
         enc <= k ? 32'd2000 : 32'd0;
         wr(SW, k ? 32'h6000 : 32'h2000, 4'hF);
         repeat (3) @(posedge aclk);
         chk("vstop", 32'h1, {31'h0, stop_q});
         wr(SW, k ? 32'h4000 : 32'h0, 4'hF);
         repeat (3) @(posedge aclk);
         chk("vstop off", 32'h0, {31'h0, stop_q});
      end
      vel <= -32'd100;
      pos <= -32'd5;
      wr(SW, 32'h1000, 4'hF);
      repeat (3) @(posedge aclk);
      chk("vstop left", 32'h1, {31'h0, stop_q});
      wr(SW, 32'h0280, 4'hF);
      pos <= 32'h1234ABCD;
      enc <= 32'h0BADF00D;
      ref_r <= 1'b1;
      repeat (8) @(posedge aclk);
      chk("latch pos", 32'h1234ABCD, cap_p);
      chk("latch enc", 32'h0BADF00D, cap_e);
      pos <= 32'h55AA55AA;
      ref_r <= 1'b0;
      repeat (8) @(posedge aclk);
      chk("no latch", 32'h1234ABCD, cap_p);
      rdr(8'hD8);
      chk("captured read", 32'h1234ABCD, rd);
      rdr(8'hD4);
      chk("latch flag", 32'h1, {31'h0, rd[7]});
      wr(8'hD4, 32'h80, 4'h1);
      rdr(8'hD4);
      chk("latch clear", 32'h0, {31'h0, rd[7]});
      give_verdict();
   end
endmodule
`default_nettype wire
